// file: logic/asr_pkg.sv
package asr_pkg;

    localparam int ADDR_W = 20;
    localparam int WORD_COUNT = 1048576;
    localparam int CLK_PERIOD_NS = 100;

    // bus timing figures in ns (slowest grade, so any grade is safe)
    localparam int READ_CYCLE_TIME_NS = 45;
    localparam int WRITE_PULSE_NS = 25;
    localparam int DESELECT_TO_RETENTION_NS = 0;
    localparam int RETENTION_RECOVERY_NS = 45;

    localparam int READ_CYC_RAW = (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC_RAW = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOV_CYC_RAW = (RETENTION_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [3:0] READ_CYCLES = 4'(READ_CYC_RAW < 1 ? 1 : READ_CYC_RAW);
    localparam logic [3:0] WRITE_CYCLES = 4'(WRITE_CYC_RAW < 1 ? 1 : WRITE_CYC_RAW);
    localparam logic [3:0] RECOVERY_CYCLES = 4'(RECOV_CYC_RAW < 1 ? 1 : RECOV_CYC_RAW);

    localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;

    typedef enum logic [2:0] {
        ASR_IDLE,
        ASR_SETUP,
        ASR_ACCESS,
        ASR_END,
        ASR_RETAIN,
        ASR_RECOVER
    } asr_state_e;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic              wdata;
    } asr_req_s;

    typedef struct packed {
        logic              select_n;
        logic              strobe_n;
        logic [ADDR_W-1:0] word_address;
        logic              data_in;
    } asr_pins_s;

endpackage

// file: logic/asr_timer.sv
`timescale 1ns/10ps
module asr_timer (
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       load_i,
    input  wire logic [3:0] count_i,
    output logic            done_o
);
    import asr_pkg::*;

    typedef struct packed {
        logic [3:0] cnt;
    } asr_tmr_s;

    asr_tmr_s st_r;
    asr_tmr_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (load_i) begin
            st_nxt.cnt = count_i;
        end else if (st_r.cnt != 4'h0) begin
            st_nxt.cnt = st_r.cnt - 4'h1;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // done when one cycle is left so a load of n spans exactly n cycles
    assign done_o = !load_i && (st_r.cnt <= 4'h1);
endmodule

// file: logic/asr_host.sv
// Operation
// - write ends when either line rises
// - address valid before select falls
// - deselect before and throughout retention
// - wait one read cycle after retention
`timescale 1ns/10ps
module asr_host (
    input  wire logic                   core_clk_i,
    input  wire logic                   reset_i,
    input  wire asr_pkg::asr_req_s      req_i,
    output logic                        req_ready_o,
    output logic                        rd_valid_o,
    output logic                        rd_data_o,
    input  wire logic                   retain_req_i,
    output logic                        retain_ok_o,
    input  wire logic                   mem_data_out_i,
    output asr_pkg::asr_pins_s          pins_o
);
    import asr_pkg::*;

    typedef struct packed {
        asr_state_e state;
        asr_pins_s  pins;
        logic       write;
        logic       rd_valid;
        logic       rd_data;
        logic       retain_ok;
    } asr_host_s;

    asr_host_s st_r;
    asr_host_s st_nxt;
    logic      tmr_load;
    logic [3:0] tmr_count;
    logic      tmr_done;

    asr_timer asr_timer_inst (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .load_i     (tmr_load),
        .count_i    (tmr_count),
        .done_o     (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_nxt = st_r;
        tmr_load = 1'b0;
        tmr_count = READ_CYCLES;
        st_nxt.rd_valid = 1'b0;
        unique case (st_r.state)
            ASR_IDLE: begin
                if (retain_req_i) begin
                    // already deselected, zero delay to retention
                    st_nxt.state = ASR_RETAIN;
                    st_nxt.retain_ok = 1'b1;
                end else if (req_i.valid) begin
                    // address and data go out first, select stays high
                    st_nxt.pins.word_address = req_i.addr;
                    st_nxt.pins.data_in = req_i.wdata;
                    st_nxt.write = req_i.write;
                    st_nxt.state = ASR_SETUP;
                end
            end
            ASR_SETUP: begin
                // select falls one cycle after the address settled
                st_nxt.pins.select_n = 1'b0;
                st_nxt.pins.strobe_n = !st_r.write;
                tmr_load = 1'b1;
                tmr_count = st_r.write ? WRITE_CYCLES : READ_CYCLES;
                st_nxt.state = ASR_ACCESS;
            end
            ASR_ACCESS: begin
                if (tmr_done) begin
                    if (!st_r.write) begin
                        // sample before release; device drives while selected
                        st_nxt.rd_data = mem_data_out_i;
                        st_nxt.rd_valid = 1'b1;
                    end
                    // strobe rises first, ending the write with data held
                    st_nxt.pins.strobe_n = 1'b1;
                    st_nxt.state = ASR_END;
                end
            end
            ASR_END: begin
                // select rises after strobe, so address and data hold past write end
                st_nxt.pins.select_n = 1'b1;
                st_nxt.state = ASR_IDLE;
            end
            ASR_RETAIN: begin
                // select pinned high for the whole retention interval
                st_nxt.pins.select_n = 1'b1;
                if (!retain_req_i) begin
                    st_nxt.retain_ok = 1'b0;
                    tmr_load = 1'b1;
                    tmr_count = RECOVERY_CYCLES;
                    st_nxt.state = ASR_RECOVER;
                end
            end
            ASR_RECOVER: begin
                if (tmr_done) begin
                    st_nxt.state = ASR_IDLE;
                end
            end
            default: begin
                st_nxt.state = ASR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r.state <= ASR_IDLE;
            st_r.pins.select_n <= 1'b1;
            st_r.pins.strobe_n <= 1'b1;
            st_r.pins.word_address <= ADDR_RESET;
            st_r.pins.data_in <= 1'b0;
            st_r.write <= 1'b0;
            st_r.rd_valid <= 1'b0;
            st_r.rd_data <= 1'b0;
            st_r.retain_ok <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign req_ready_o = (st_r.state == ASR_IDLE) && !retain_req_i;
    assign rd_valid_o = st_r.rd_valid;
    assign rd_data_o = st_r.rd_data;
    assign retain_ok_o = st_r.retain_ok;
    assign pins_o = st_r.pins;
endmodule

// file: testbench/asr_host_asserts.sv
`timescale 1ns/10ps
module asr_host_asserts (
    input wire logic               core_clk_i,
    input wire logic               reset_i,
    input wire asr_pkg::asr_req_s  req_i,
    input wire logic               req_ready_o,
    input wire logic               rd_valid_o,
    input wire logic               retain_ok_o,
    input wire asr_pkg::asr_pins_s pins_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    wire logic take = req_i.valid && req_ready_o;
    chk_read_answer: assert property (take && !req_i.write |-> ##[2:6] rd_valid_o)
        else $error("no read data");
    chk_valid_pulse: assert property (rd_valid_o |=> !rd_valid_o)
        else $error("valid too long");
    chk_strobe_inside: assert property (!pins_o.strobe_n |-> !pins_o.select_n)
        else $error("strobe unselected");
    chk_write_end: assert property ($rose(pins_o.strobe_n) |-> ##1 pins_o.select_n)
        else $error("select late");
    chk_data_held: assert property (!pins_o.strobe_n |=> $stable(pins_o.data_in))
        else $error("data moved");
    chk_addr_first: assert property ($fell(pins_o.select_n) |-> $stable(pins_o.word_address))
        else $error("address late");
    chk_retain_idle: assert property (retain_ok_o |-> pins_o.select_n)
        else $error("selected in retention");
    chk_recovery_gap: assert property ($fell(retain_ok_o) |-> pins_o.select_n [*2])
        else $error("no recovery");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind asr_host asr_host_asserts asr_host_asserts_inst (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .rd_valid_o(rd_valid_o), .retain_ok_o(retain_ok_o), .pins_o(pins_o));

// file: testbench/asr_sram_model.sv
`timescale 1ns/10ps
module asr_sram_model (
    input  wire asr_pkg::asr_pins_s pins_i,
    output logic                    data_out_o
);
    import asr_pkg::*;
    logic mem [int];
    logic last = 1'b0;
    wire logic wr = !pins_i.select_n && !pins_i.strobe_n;
    always @(negedge wr) mem[pins_i.word_address] = pins_i.data_in;
    always @(pins_i or wr) begin
        if (!pins_i.select_n && pins_i.strobe_n) begin
            last = mem.exists(pins_i.word_address) ? mem[pins_i.word_address] : 1'b0;
            data_out_o = last;
        end else begin
            // released line shows no stale bit
            data_out_o = ~last;
        end
    end
endmodule

// file: testbench/async_sram_1m_by_1_test.sv
`timescale 1ns/10ps
module async_sram_1m_by_1_test;
    import asr_pkg::*;
    logic      core_clk_i = 1'b0, reset_i = 1'b1, retain_req_i = 1'b0, mem_q;
    logic      req_ready_o, rd_valid_o, rd_data_o, retain_ok_o;
    asr_req_s  req_i = '0;
    asr_pins_s pins_o;
    int        n_mismatch = 0, check_count = 0;
    logic [19:0] tab [4] = '{20'h00000, 20'hFFFFF, 20'h5A5A5, 20'h00001};
    always #50 core_clk_i = ~core_clk_i;
    asr_host asr_host_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .req_i(req_i),
        .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .retain_req_i(retain_req_i), .retain_ok_o(retain_ok_o), .mem_data_out_i(mem_q),
        .pins_o(pins_o));
    asr_sram_model asr_sram_model_inst (.pins_i(pins_o), .data_out_o(mem_q));
    task automatic check_bit(string what, logic exp, logic got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // all driving sits 1 ns after the rising edge
    task automatic access(logic wr, logic [19:0] a, logic d, logic exp);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 20) begin
            @(posedge core_clk_i);
            #1 n++;
        end
        check_bit("request ready", 1'b1, req_ready_o);
        req_i = '{1'b1, wr, a, d};
        @(posedge core_clk_i);
        #1 req_i.valid = 1'b0;
        while (!wr && rd_valid_o !== 1'b1 && n < 40) begin
            @(posedge core_clk_i);
            #1 n++;
        end
        // a read that never answers must not pass on stale data
        if (!wr) check_bit("read valid", 1'b1, rd_valid_o);
        if (!wr) check_bit("read data", exp, rd_data_o);
    endtask
    task automatic test_rw();
        check_bit("idle select", 1'b1, pins_o.select_n);
        check_bit("idle strobe", 1'b1, pins_o.strobe_n);
        check_bit("idle ready", 1'b1, req_ready_o);
        check_bit("idle valid", 1'b0, rd_valid_o);
        check_bit("idle retain", 1'b0, retain_ok_o);
        foreach (tab[i]) access(1'b1, tab[i], i[0], 1'b0);
        access(1'b1, tab[2], 1'b1, 1'b0);
        foreach (tab[i]) access(1'b0, tab[i], 1'b0, (i == 2) | i[0]);
        $display("test_rw done");
    endtask
    task automatic test_retain();
        retain_req_i = 1'b1;
        repeat (3) @(posedge core_clk_i);
        #1 check_bit("retain ok", 1'b1, retain_ok_o);
        check_bit("deselected", 1'b1, pins_o.select_n);
        retain_req_i = 1'b0;
        access(1'b0, tab[1], 1'b0, 1'b1);
        check_bit("retain off", 1'b0, retain_ok_o);
        $display("test_retain done");
    endtask
    initial begin
        repeat (10) @(posedge core_clk_i);
        #1 reset_i = 1'b0;
        test_rw();
        test_retain();
        complete_run();
    end
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule
